// ---- logic/fscp_params.svh ----
`ifndef FSCP_PARAMS_SVH
`define FSCP_PARAMS_SVH

// frame geometry
`define FSCP_FRAME_BITS 6'd32
`define FSCP_CNT_OVER 6'd33
`define FSCP_CNT_W 6
`define FSCP_DATA_W 24
`define FSCP_ADDR_W 5
`define FSCP_CODE_W 3
`define FSCP_NUM_REGS 32

// register 0 layout
`define FSCP_PTR_REG 5'h00
`define FSCP_PTR_MSB 4
`define FSCP_SOFT_RST_BIT 5

// reset values
`define FSCP_REG_DEFAULT 24'h000000
`define FSCP_PTR_DEFAULT 5'h00
`define FSCP_WORD_ZERO 32'h00000000
`define FSCP_SEL_IDLE 1'h1

`endif

// ---- logic/fscp_pkg.sv ----
package fscp_pkg;

    // one serial frame, first bit received in the top bit
    typedef struct packed {
        logic [23:0] data;
        logic [4:0] addr;
        logic [2:0] code;
    } fscp_frame_s;

    // register write handed to the user side
    typedef struct packed {
        logic [4:0] addr;
        logic [23:0] data;
    } fscp_wr_s;

    // whether the serial output is being driven
    typedef enum logic [0:0] {
        FSCP_OUT_RELEASED = 1'b0,
        FSCP_OUT_DRIVEN = 1'b1
    } fscp_out_e;

endpackage

// ---- logic/fscp_port.sv ----
`timescale 1ns/1ps
`include "fscp_params.svh"
// Notes on behaviour
// R1 - first input bit, the data MSB, sampled on first rising clock after select low
// R2 - frame opens with 24 data bits, MSB first, on consecutive rising edges
// R3 - then 5 register address bits, MSB first, captured on rising edges
// R4 - last 3 bits are chip address; frame acts only when it matches code
// R5 - host ends a write frame by raising select after the 32nd rising edge
// R6 - host raises select after 32nd falling edge, before next rising edge
// R7 - captured data committed to the register only when select rises
// R8 - device changes output on rising edges; host samples on falling edges
// R9 - output released unless addressed; after addressing, driven during next frame
// R10 - host reads by writing target address into register 0, then second frame
// R11 - a read always takes two whole frames: pointer load, then data return; here every frame returns the register read_ptr already holds
// R12 - register 0 bits 4..0 hold the pointer selecting the next frame's output
// R13 - next frame shifts out 24 data, 5 address, 3 code bits, MSB first
// R14 - host raises select only after capturing all 32 output bits
// R15 - host resends the same pointer to register 0 during the return frame
// R16 - each device on a shared bus gets its own select line
// R17 - host ends access with a non-matching frame so output is released
// R18 - a non-matching chip address leaves every configuration register unchanged
// R19 - writing 20h then 0h to register 0 returns registers to defaults
// R20 - host clears soft reset bit afterwards; writing zero changes nothing
// R21 - a frame not exactly 32 bits long is discarded without any update
module fscp_port #(
    // arbitrary value, chosen for this design
    parameter logic [2:0] DEVICE_SELECT_CODE = 3'h3,
    // arbitrary value returned when register 0 is read
    parameter logic [23:0] DEVICE_ID_WORD = 24'h00A5C3
) (
    // system side
    input wire logic clk,
    input wire logic rst,
    // serial pins
    input wire logic port_select_low,
    input wire logic ser_clk,
    input wire logic ser_in,
    output logic ser_out,
    output logic ser_out_oe_n,
    // configuration updates towards the device logic
    output logic cfg_wr,
    output fscp_pkg::fscp_wr_s cfg,
    output logic soft_rst,
    output logic [4:0] read_ptr
);

    // ---------------- link domain, on ser_clk ----------------
    logic [`FSCP_CNT_W-1:0] bit_cnt;
    logic [31:0] shift_in;
    logic [31:0] read_word;
    logic fresh;
    logic [`FSCP_CNT_W-1:0] edge_idx;

    // set while select is high, so the next rising edge opens a new frame;
    // the count itself must survive select so the system side can judge
    // the frame length after select has risen
    always_ff @(posedge ser_clk or posedge port_select_low or posedge rst)
    begin
        if (rst || port_select_low)
            fresh <= 1'b1;
        else
            fresh <= 1'b0;
    end

    // position of the current rising edge within the frame
    assign edge_idx = fresh ? '0 : bit_cnt;

    // edges seen in the last frame; saturates past 32 so an overlong
    // frame is recognisable
    always_ff @(posedge ser_clk or posedge rst)
    begin
        if (rst)
            bit_cnt <= '0;
        else if (edge_idx != `FSCP_CNT_OVER)
            bit_cnt <= edge_idx + 1'b1;
    end

    // input shifter, MSB first on rising edges; fields land in order
    always_ff @(posedge ser_clk or posedge rst)
    begin
        if (rst)
            shift_in <= `FSCP_WORD_ZERO;
        else if (edge_idx < `FSCP_FRAME_BITS)
            shift_in <= {shift_in[30:0], ser_in}; // R1 R2 R3 R4
    end

    // output bit changes on rising edges, the first edge giving the MSB;
    // read_word is quiet here because it only moves between frames
    always_ff @(posedge ser_clk or posedge rst)
    begin
        if (rst)
            ser_out <= 1'b0;
        else if (edge_idx < `FSCP_FRAME_BITS)
            ser_out <= read_word[5'd31 - edge_idx[4:0]]; // R8 R13
    end

    // ---------------- system domain, on clk ----------------
    logic sel_meta;
    logic sel_sync;
    logic sel_prev;
    logic frame_end;
    fscp_pkg::fscp_frame_s frame;
    logic frame_full;
    logic frame_match;
    logic [23:0] regs [0:`FSCP_NUM_REGS-1];
    fscp_pkg::fscp_out_e out_state;

    // select pin synchroniser; sel_meta feeds sel_sync only
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sel_meta <= `FSCP_SEL_IDLE;
            sel_sync <= `FSCP_SEL_IDLE;
            sel_prev <= `FSCP_SEL_IDLE;
        end
        else
        begin
            sel_meta <= port_select_low;
            sel_sync <= sel_meta;
            sel_prev <= sel_sync;
        end
    end

    // the frame is taken over only after select has risen, when ser_clk
    // is no longer moving, so the link-domain words are stable to read
    assign frame_end = sel_sync & ~sel_prev; // R7
    assign frame = shift_in;
    assign frame_full = (bit_cnt == `FSCP_FRAME_BITS); // R21
    assign frame_match = (frame.code == DEVICE_SELECT_CODE); // R4 R18

    // register file; soft reset restores defaults and keeps bit 5 state out
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < `FSCP_NUM_REGS; i++)
                regs[i] <= `FSCP_REG_DEFAULT;
        end
        else if (frame_end && frame_full && frame_match)
        begin
            if (frame.addr == `FSCP_PTR_REG &&
                frame.data[`FSCP_SOFT_RST_BIT])
            begin
                for (int i = 0; i < `FSCP_NUM_REGS; i++)
                    regs[i] <= `FSCP_REG_DEFAULT; // R19
            end
            else
                regs[frame.addr] <= frame.data; // R7
        end
    end

    // read pointer lives in register 0 bits 4..0
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            read_ptr <= `FSCP_PTR_DEFAULT;
        else if (frame_end && frame_full && frame_match &&
                 frame.addr == `FSCP_PTR_REG)
            read_ptr <= frame.data[`FSCP_PTR_MSB:0]; // R12 R19
    end

    // word for the next frame: selected contents, pointer, select code;
    // built one cycle after the commit, so select must stay high a while
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            read_word <= `FSCP_WORD_ZERO;
        else if (sel_sync)
        begin
            if (read_ptr == `FSCP_PTR_REG)
                read_word <= {DEVICE_ID_WORD, read_ptr,
                              DEVICE_SELECT_CODE}; // R13
            else
                read_word <= {regs[read_ptr], read_ptr,
                              DEVICE_SELECT_CODE}; // R13
        end
    end

    // output driven from a matching frame until a full non-matching one
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            out_state <= fscp_pkg::FSCP_OUT_RELEASED;
        else if (frame_end && frame_full)
            out_state <= frame_match ? fscp_pkg::FSCP_OUT_DRIVEN
                                     : fscp_pkg::FSCP_OUT_RELEASED; // R9
    end

    // enable registered again so it comes straight from a flop
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ser_out_oe_n <= 1'b1;
        else
            ser_out_oe_n <= (out_state != fscp_pkg::FSCP_OUT_DRIVEN); // R9
    end

    // write notification and soft reset pulse towards the device logic
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_wr <= 1'b0;
            cfg <= '0;
            soft_rst <= 1'b0;
        end
        else
        begin
            cfg_wr <= frame_end && frame_full && frame_match; // R18 R21
            soft_rst <= frame_end && frame_full && frame_match &&
                        frame.addr == `FSCP_PTR_REG &&
                        frame.data[`FSCP_SOFT_RST_BIT]; // R19
            if (frame_end && frame_full && frame_match)
                cfg <= '{addr: frame.addr, data: frame.data};
        end
    end

endmodule

// ---- tb/fscp_monitor.sv ----
`timescale 1ns/1ps
// watches the pins and commit outputs of the port
module fscp_monitor (
    // system side
    input wire logic clk,
    input wire logic rst,
    // serial pins
    input wire logic port_select_low,
    input wire logic ser_clk,
    input wire logic ser_out,
    input wire logic ser_out_oe_n,
    // commit side
    input wire logic cfg_wr,
    input fscp_pkg::fscp_wr_s cfg,
    input wire logic soft_rst,
    input wire logic [4:0] read_ptr
);
    logic last_fall;
    // level at the last falling edge; reset keeps it defined
    always_ff @(negedge ser_clk or posedge rst)
    begin
        if (rst)
            last_fall <= 1'h0;
        else
            last_fall <= ser_out;
    end
    property p_out_edge;
        @(posedge ser_clk) disable iff (rst)
        !port_select_low |-> ser_out == last_fall;
    endproperty
    a_out_edge: assert property (p_out_edge) else $error("sdo edge");
    property p_wr_pulse;
        @(posedge clk) disable iff (rst) cfg_wr |=> !cfg_wr;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("wr long");
    property p_wr_idle;
        @(posedge clk) disable iff (rst) cfg_wr |-> port_select_low;
    endproperty
    a_wr_idle: assert property (p_wr_idle) else $error("wr in frame");
    property p_soft;
        @(posedge clk) disable iff (rst)
        soft_rst |-> cfg_wr && cfg.addr == 5'h00 && cfg.data[5];
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset cause");
    property p_cfg_hold;
        @(posedge clk) disable iff (rst) $changed(cfg) |-> cfg_wr;
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("cfg moved");
    property p_ptr;
        @(posedge clk) disable iff (rst) $changed(read_ptr) |->
        cfg_wr && cfg.addr == 5'h00 && read_ptr == cfg.data[4:0];
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer moved");
    property p_oe_fall;
        @(posedge clk) disable iff (rst)
        $fell(ser_out_oe_n) |-> $past(cfg_wr) || $past(cfg_wr, 2);
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("oe fell");
    property p_oe_rise;
        @(posedge clk) disable iff (rst)
        $rose(ser_out_oe_n) |-> port_select_low;
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("oe rose");
    c_wr: cover property (@(posedge clk) cfg_wr);
    c_soft: cover property (@(posedge clk) soft_rst);
    c_drive: cover property (@(posedge clk) $fell(ser_out_oe_n));
endmodule
bind fscp_port fscp_monitor fscp_monitor_inst (.*);

// ---- tb/fscp_host.sv ----
`timescale 1ns/1ps
// bus master: clock idles low, data moves on falling edges
module fscp_host (
    // serial pins
    output logic port_select_low,
    output logic ser_clk,
    output logic ser_in,
    input wire logic sdo_line
);
    initial
    begin
        port_select_low = 1'h1;
        ser_clk = 1'h0;
        ser_in = 1'h0;
    end
    // n bits of w, MSB first; rd gathers the output bits
    task automatic xfer(input logic [31:0] w, input int n,
        output logic [31:0] rd);
        rd = 32'h00000000;
        ser_in = w[31];
        port_select_low = 1'h0;
        #15;
        for (int i = 0; i < n; i++)
        begin
            ser_clk = 1'h1;
            #15;
            ser_clk = 1'h0;
            rd = {rd[30:0], sdo_line};
            ser_in = w[(30 - i) & 31];
            #15;
        end
        port_select_low = 1'h1;
    endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
// regression for the serial configuration port
module tb_top;
    localparam logic [2:0] C = 3'h3;
    logic clk, rst, port_select_low, ser_clk, ser_in, sdo_line;
    logic ser_out, ser_out_oe_n, cfg_wr, soft_rst;
    logic [4:0] read_ptr;
    logic [31:0] rd;
    fscp_pkg::fscp_wr_s cfg;
    int fails = 0, cmp_count = 0, wr_cnt = 0;
    fscp_port fscp_port_inst (.*);
    fscp_host fscp_host_inst (.*);
    // released output shows the inverse of what the pin last carried
    assign sdo_line = ser_out_oe_n ? ~ser_out : ser_out;
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (cfg_wr === 1'h1)
            wr_cnt <= wr_cnt + 1;
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // select stays high long enough for the read word to rebuild
    task automatic fr(input logic [31:0] w, input int n);
        fscp_host_inst.xfer(w, n, rd);
        repeat (8) @(negedge clk);
    endtask
    task automatic t_write;
        fr({24'h5A5A5A, 5'h03, C}, 32);
        chk("cfg", {3'h0, 5'h03, 24'h5A5A5A}, {3'h0, cfg});
        fr({24'h000003, 5'h00, C}, 32);
        chk("read_ptr", 32'h00000003, {27'h0, read_ptr});
        fr({24'h000003, 5'h00, C}, 32);
        chk("read word", {24'h5A5A5A, 5'h03, C}, rd);
        chk("oe_n", 32'h00000000, {31'h0, ser_out_oe_n});
        $display("t_write done");
    endtask
    task automatic t_refuse;
        fr({24'h123456, 5'h03, 3'h4}, 32);
        chk("read word", {24'h5A5A5A, 5'h03, C}, rd);
        chk("oe_n", 32'h00000001, {31'h0, ser_out_oe_n});
        fr({24'h123456, 5'h03, C}, 31);
        chk("writes", 32'h00000003, wr_cnt);
        chk("cfg", {3'h0, 5'h00, 24'h000003}, {3'h0, cfg});
        $display("t_refuse done");
    endtask
    task automatic t_soft;
        fr({24'h000020, 5'h00, C}, 32);
        fr({24'h000000, 5'h00, C}, 32);
        fr({24'h000003, 5'h00, C}, 32);
        chk("id word", {24'h00A5C3, 5'h00, C}, rd);
        fr({24'h000003, 5'h00, C}, 32);
        chk("read word", {24'h000000, 5'h03, C}, rd);
        $display("t_soft done");
    endtask
    task automatic finish_test;
        $display("checks %0d fails %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #200000;
        fails++;
        finish_test;
    end
    initial
    begin
        rst = 1'h1;
        repeat (10) @(negedge clk);
        rst = 1'h0;
        repeat (5) @(negedge clk);
        t_write;
        t_refuse;
        t_soft;
        finish_test;
    end
endmodule
